// File: inc/ssio_consts.svh
/*
 * Constants of the segment-shared I/O port: register indices, reset
 * values, segment_select codes and field widths.
 * Assumes inclusion by bare name before the package and the modules.
 */
`ifndef SSIO_CONSTS_SVH
`define SSIO_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define SSIO_IDX_P8_LATCH   16'hFFDB
`define SSIO_IDX_P8_DIR     16'hFFEB
`define SSIO_IDX_P7_LATCH   16'hFFDA
`define SSIO_IDX_P7_DIR     16'hFFEA
`define SSIO_IDX_LCD_CTRL   16'hFFC0

// Reset values.
`define SSIO_RST_LATCH      8'h00
`define SSIO_RST_DIR        8'h00
`define SSIO_RST_SEL        4'h0

// Read value of the write-only direction registers.
`define SSIO_DIR_READ       8'hFF

// Field layout of lcd_port_control.
`define SSIO_SEL_MSB        3
`define SSIO_SEL_LSB        0

// segment_select codes that are compared exactly.
`define SSIO_SEL_P7LO_GP    4'h4
`define SSIO_SEL_P8LO_GP    4'h2

// Pin and bus widths.
`define SSIO_PORT_W         8
`define SSIO_DATA_W         32
`define SSIO_ADDR_W         32

// Fill values.
`define SSIO_BYTE_ZERO      8'h00
`define SSIO_BYTE_ONES      8'hFF
`define SSIO_WORD_ZERO      32'h00000000

`endif

// File: inc/ssio_pkg.sv
/*
 * Types of the segment-shared I/O port: the power mode enumeration.
 * Assumes the power controller drives the mode on the core clock.
 */
package ssio_pkg;

  // Operating modes as seen by the port pins.
  typedef enum logic [2:0] {
    SSIO_ACTIVE,
    SSIO_SUBACTIVE,
    SSIO_SLEEP,
    SSIO_SUBSLEEP,
    SSIO_WATCH,
    SSIO_STANDBY
  } ssio_pwr_e;

  typedef logic [7:0] ssio_byte_t;

endpackage

// File: core/ssio_pin_sync.sv
/*
 * Two-stage synchroniser for the sixteen port pin inputs.
 * Assumes the pins are asynchronous to i_core_clk.
 */
`timescale 1ns/1ps
module ssio_pin_sync (
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic [15:0] i_async,
  output logic      [15:0] o_sync
);

  logic [15:0] meta_q;
  logic [15:0] sync_q;

  // First stage feeds only the second stage.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= 16'h0000;
      sync_q <= 16'h0000;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

// File: core/ssio_port.sv
/*
 * Segment-shared general I/O ports 7 and 8 with an APB register slave.
 * Assumes an APB master on i_core_clk, segment data from the LCD
 * controller on the same clock, and a power mode from the power
 * controller on the same clock. Pin levels arrive asynchronously.
 */
// Our own choice: register access over APB.
// Operation
// - Port 7 low nibble function by segment_select
// - Port 7 hi-Z in reset, standby; hold sleeping
// - Latch and direction registers at fixed indices
// - Reset clears port 8 output latch
// - Output bits read back latch value
// - Input bits read live pin level
// - Direction one drives pin from latch
// - Segment function overrides direction and latch
// - Direction register always reads all ones
// - Reset clears port 8 direction register
// - Port 8 nibble functions by segment_select
// - Port 7 high nibble function by segment_select
`timescale 1ns/1ps
`include "ssio_consts.svh"
module ssio_port
  import ssio_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  ssio_pwr_e        i_pwr_mode,
  input  wire logic [7:0]  i_seg7_data,
  input  wire logic [7:0]  i_seg8_data,
  input  wire logic [7:0]  i_p7_pin,
  input  wire logic [7:0]  i_p8_pin,
  output logic      [7:0]  o_p7_out,
  output logic      [7:0]  o_p7_oe,
  output logic      [7:0]  o_p8_out,
  output logic      [7:0]  o_p8_oe
);

  // Byte address of a register index.
  function automatic logic [31:0] reg_addr(input logic [15:0] idx);
    reg_addr = {14'h0000, idx, 2'b00};
  endfunction

  // Pin value read by software: latch for outputs, pin for inputs.
  function automatic ssio_byte_t port_read(input ssio_byte_t latch,
                                           input ssio_byte_t dir,
                                           input ssio_byte_t pin);
    port_read = (latch & dir) | (pin & ~dir);
  endfunction

  // Builds a per-pin general I/O mask from two nibble decisions.
  function automatic ssio_byte_t nib_mask(input logic hi_gp,
                                          input logic lo_gp);
    nib_mask = {{4{hi_gp}}, {4{lo_gp}}};
  endfunction

  // Pin drive: general I/O bits follow latch and direction,
  // segment bits drive segment data.
  function automatic ssio_byte_t mux_out(input ssio_byte_t gp,
                                         input ssio_byte_t latch,
                                         input ssio_byte_t segment_output);
    mux_out = (gp & latch) | (~gp & segment_output);
  endfunction

  function automatic ssio_byte_t mux_oe(input ssio_byte_t gp,
                                        input ssio_byte_t dir);
    mux_oe = (gp & dir) | ~gp;
  endfunction

  ssio_byte_t  p8_latch_q;
  ssio_byte_t  p8_dir_q;
  ssio_byte_t  p7_latch_q;
  ssio_byte_t  p7_dir_q;
  logic [3:0]  seg_sel_q;
  logic [31:0] rdata_q;
  ssio_byte_t  p7_out_q;
  ssio_byte_t  p7_oe_q;
  ssio_byte_t  p8_out_q;
  ssio_byte_t  p8_oe_q;
  logic [15:0] pin_sync;
  ssio_byte_t  p7_pin;
  ssio_byte_t  p8_pin;

  // Pin levels pass two flip-flops before any logic reads them.
  ssio_pin_sync u_sync (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_async    ({i_p8_pin, i_p7_pin}),
    .o_sync     (pin_sync)
  );

  assign p7_pin = pin_sync[7:0];
  assign p8_pin = pin_sync[15:8];

  // Address decoding for the APB slave.
  wire hit_p8_latch = (paddr == reg_addr(`SSIO_IDX_P8_LATCH));
  wire hit_p8_dir   = (paddr == reg_addr(`SSIO_IDX_P8_DIR));
  wire hit_p7_latch = (paddr == reg_addr(`SSIO_IDX_P7_LATCH));
  wire hit_p7_dir   = (paddr == reg_addr(`SSIO_IDX_P7_DIR));
  wire hit_lcd      = (paddr == reg_addr(`SSIO_IDX_LCD_CTRL));
  wire hit_any      = hit_p8_latch | hit_p8_dir | hit_p7_latch |
                      hit_p7_dir | hit_lcd;

  // Bus phases; the slave never inserts wait states.
  wire setup_ph  = psel & ~penable;
  wire access_ph = psel & penable;
  wire wr_ok     = access_ph & pwrite & hit_any;

  assign pready  = access_ph;
  assign pslverr = access_ph & ~hit_any;
  assign prdata  = rdata_q;

  // Read mux, selected by if and else-if on the address.
  ssio_byte_t p8_view;
  ssio_byte_t p7_view;
  logic [31:0] rd_word;

  assign p8_view = port_read(p8_latch_q, p8_dir_q, p8_pin);
  assign p7_view = port_read(p7_latch_q, p7_dir_q, p7_pin);

  always_comb begin
    rd_word = `SSIO_WORD_ZERO;
    if (hit_p8_latch) begin
      rd_word = {24'h000000, p8_view};
    end else if (hit_p7_latch) begin
      rd_word = {24'h000000, p7_view};
    end else if (hit_p8_dir || hit_p7_dir) begin
      rd_word = {24'h000000, `SSIO_DIR_READ};
    end else if (hit_lcd) begin
      rd_word = {28'h0000000, seg_sel_q};
    end else begin
      rd_word = `SSIO_WORD_ZERO;
    end
  end

  // Read data is captured in the setup cycle and stands for access.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= `SSIO_WORD_ZERO;
    end else if (setup_ph && !pwrite) begin
      rdata_q <= rd_word;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      p8_latch_q <= `SSIO_RST_LATCH;
      p8_dir_q   <= `SSIO_RST_DIR;
      p7_latch_q <= `SSIO_RST_LATCH;
      p7_dir_q   <= `SSIO_RST_DIR;
      seg_sel_q  <= `SSIO_RST_SEL;
    end else if (wr_ok) begin
      if (hit_p8_latch) begin
        p8_latch_q <= pwdata[7:0];
      end else if (hit_p8_dir) begin
        p8_dir_q <= pwdata[7:0];
      end else if (hit_p7_latch) begin
        p7_latch_q <= pwdata[7:0];
      end else if (hit_p7_dir) begin
        p7_dir_q <= pwdata[7:0];
      end else if (hit_lcd) begin
        seg_sel_q <= pwdata[`SSIO_SEL_MSB:`SSIO_SEL_LSB];
      end
    end
  end

  // Per-nibble function selection from segment_select.
  // port 7 high nibble
  wire p7_hi_gp = (seg_sel_q[3:2] == 2'b00);
  wire p7_lo_gp = (seg_sel_q[3:2] == 2'b00) ||
                  (seg_sel_q == `SSIO_SEL_P7LO_GP);
  wire p8_hi_gp = (seg_sel_q[3:1] == 3'b000);
  wire p8_lo_gp = (seg_sel_q[3:1] == 3'b000) ||
                  (seg_sel_q == `SSIO_SEL_P8LO_GP);

  ssio_byte_t p7_gp;
  ssio_byte_t p8_gp;
  assign p7_gp = nib_mask(p7_hi_gp, p7_lo_gp);
  assign p8_gp = nib_mask(p8_hi_gp, p8_lo_gp);

  // Next pin drive while the port is functional.
  ssio_byte_t p7_out_fn;
  ssio_byte_t p7_oe_fn;
  ssio_byte_t p8_out_fn;
  ssio_byte_t p8_oe_fn;
  assign p7_out_fn = mux_out(p7_gp, p7_latch_q, i_seg7_data);
  assign p7_oe_fn  = mux_oe(p7_gp, p7_dir_q);
  assign p8_out_fn = mux_out(p8_gp, p8_latch_q, i_seg8_data);
  assign p8_oe_fn  = mux_oe(p8_gp, p8_dir_q);

  // Power mode classes.
  wire mode_fn     = (i_pwr_mode == SSIO_ACTIVE) ||
                     (i_pwr_mode == SSIO_SUBACTIVE);
  wire mode_hiz    = (i_pwr_mode == SSIO_STANDBY);

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      p7_out_q <= `SSIO_BYTE_ZERO;
      p7_oe_q  <= `SSIO_BYTE_ZERO;
      p8_out_q <= `SSIO_BYTE_ZERO;
      p8_oe_q  <= `SSIO_BYTE_ZERO;
    end else if (mode_hiz) begin
      p7_out_q <= `SSIO_BYTE_ZERO;
      p7_oe_q  <= `SSIO_BYTE_ZERO;
      p8_out_q <= `SSIO_BYTE_ZERO;
      p8_oe_q  <= `SSIO_BYTE_ZERO;
    end else if (mode_fn) begin
      p7_out_q <= p7_out_fn;
      p7_oe_q  <= p7_oe_fn;
      p8_out_q <= p8_out_fn;
      p8_oe_q  <= p8_oe_fn;
    end
  end

  assign o_p7_out = p7_out_q;
  assign o_p7_oe  = p7_oe_q;
  assign o_p8_out = p8_out_q;
  assign o_p8_oe  = p8_oe_q;

  // Checks that tie outputs to their causes.

  property p_latch_write;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (access_ph && pwrite && hit_p8_latch)
      |=> (p8_latch_q == $past(pwdata[7:0]));
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("Port 8 latch did not take the written byte.");

  property p_write_drives;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (access_ph && pwrite && hit_p8_latch && p8_hi_gp && p8_lo_gp)
      ##1 (mode_fn && p8_dir_q == `SSIO_BYTE_ONES)
      |=> (o_p8_out == $past(pwdata[7:0], 2));
  endproperty
  a_write_drives: assert property (p_write_drives)
    else $error("Output pins did not follow a latch write.");

  property p_read_mix;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (setup_ph && !pwrite && hit_p8_latch)
      |=> (prdata[7:0] == (($past(p8_latch_q) & $past(p8_dir_q)) |
                           ($past(p8_pin) & ~$past(p8_dir_q))))
          && pready;
  endproperty
  a_read_mix: assert property (p_read_mix)
    else $error("Port 8 read did not mix latch and pin by direction.");

  property p_dir_ones;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (setup_ph && !pwrite && (hit_p8_dir || hit_p7_dir))
      |=> (prdata == {24'h000000, `SSIO_DIR_READ});
  endproperty
  a_dir_ones: assert property (p_dir_ones)
    else $error("Direction register did not read as all ones.");

  property p_standby_hiz;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      mode_hiz |=> (o_p7_oe == `SSIO_BYTE_ZERO) &&
                   (o_p8_oe == `SSIO_BYTE_ZERO);
  endproperty
  a_standby_hiz: assert property (p_standby_hiz)
    else $error("A pin was driven during standby.");

  property p_retain;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (!mode_fn && !mode_hiz) |=> $stable(o_p7_out) && $stable(o_p7_oe)
                                  && $stable(o_p8_out) && $stable(o_p8_oe);
  endproperty
  a_retain: assert property (p_retain)
    else $error("Pin state changed in a retaining mode.");

  property p_p8_oe;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      mode_fn |=> (o_p8_oe == (($past(p8_dir_q) & $past(p8_gp)) |
                               ~$past(p8_gp)));
  endproperty
  a_p8_oe: assert property (p_p8_oe)
    else $error("Port 8 enables ignore direction or segment override.");

  // code 0011 segment on port 8
  property p_p8_seg;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (mode_fn && seg_sel_q == 4'h3) |=>
        (o_p8_out == $past(i_seg8_data)) && (o_p8_oe == `SSIO_BYTE_ONES);
  endproperty
  a_p8_seg: assert property (p_p8_seg)
    else $error("Port 8 did not drive segments for code 0011.");

  property p_p7_split;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (mode_fn && seg_sel_q == `SSIO_SEL_P7LO_GP) |=>
        (o_p7_oe[7:4] == 4'hF) && (o_p7_oe[3:0] == $past(p7_dir_q[3:0]))
        && (o_p7_out[7:4] == $past(i_seg7_data[7:4]));
  endproperty
  a_p7_split: assert property (p_p7_split)
    else $error("Port 7 nibbles misassigned for code 0100.");

  property p_p7_hi;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (mode_fn && seg_sel_q[3:2] == 2'b01 &&
       seg_sel_q != `SSIO_SEL_P7LO_GP) |=>
        (o_p7_oe == `SSIO_BYTE_ONES);
  endproperty
  a_p7_hi: assert property (p_p7_hi)
    else $error("Port 7 did not drive segments for codes 0101 to 0111.");

  property p_reset_vals;
    @(posedge i_core_clk)
      $rose(i_arst_n) |-> (p8_latch_q == `SSIO_RST_LATCH) &&
                          (p8_dir_q == `SSIO_RST_DIR);
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("Port 8 registers not cleared by reset.");

  // Unmapped addresses answer with an error and change no register.
  property p_unmapped;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (access_ph && !hit_any) |-> (pslverr && pready) ##1
        ($stable(p8_latch_q) && $stable(p8_dir_q) && $stable(seg_sel_q));
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped access did not answer with an error.");

endmodule

// File: test/ssio_port_tb_top.sv
/*
 * Self-checking bench of the segment-shared I/O port.
 * Assumes the port answers APB with zero wait states and updates pins
 * one cycle after a register change; assertions sit in the design.
 */
`timescale 1ns/1ps
`include "ssio_consts.svh"
module ssio_port_tb_top
  import ssio_pkg::*;
;
  logic        i_core_clk;
  logic        i_arst_n;
  logic        psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata;
  logic        pready, pslverr;
  ssio_pwr_e   i_pwr_mode;
  logic [7:0]  i_seg7_data, i_seg8_data, i_p7_pin, i_p8_pin;
  logic [7:0]  o_p7_out, o_p7_oe, o_p8_out, o_p8_oe;
  logic [7:0]  d7, l7, d8, l8, s7, s8;
  logic [31:0] e0;
  logic [32:0] eb;
  logic        pin_chk;
  logic [32:0] bq[$];
  logic [31:0] pq[$];
  int          mismatches, checks_done, cyc;
  ssio_pwr_e   hm[3] = '{SSIO_SLEEP, SSIO_SUBSLEEP, SSIO_WATCH};

  ssio_port uut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_pwr_mode(i_pwr_mode),
    .i_seg7_data(i_seg7_data), .i_seg8_data(i_seg8_data),
    .i_p7_pin(i_p7_pin), .i_p8_pin(i_p8_pin), .o_p7_out(o_p7_out),
    .o_p7_oe(o_p7_oe), .o_p8_out(o_p8_out), .o_p8_oe(o_p8_oe));

  // Core clock of 50 MHz.
  always #10 i_core_clk = ~i_core_clk;

  // Byte address is four times the register index.
  function automatic logic [31:0] ba(input logic [15:0] idx);
    return {14'h0000, idx, 2'b00};
  endfunction

  // Expected {p8 oe, p8 driven bits, p7 oe, p7 driven bits}.
  function automatic logic [31:0] ep(input logic [3:0] g);
    logic [7:0] m7, m8, o7, o8;
    m7 = {{4{g[3:2] == 2'h0}}, {4{g[3:2] == 2'h0 || g == 4'h4}}};
    m8 = {{4{g[3:1] == 3'h0}}, {4{g[3:1] == 3'h0 || g == 4'h2}}};
    o7 = (m7 & d7) | ~m7;
    o8 = (m8 & d8) | ~m8;
    return {o8, o8 & ((m8 & l8) | (~m8 & s8)),
            o7, o7 & ((m7 & l7) | (~m7 & s7))};
  endfunction

  task automatic chk(input string nm, input logic [32:0] e,
                     input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; the expected {pslverr, prdata} goes to the queue.
  task automatic xfer(input logic [15:0] idx, input logic w,
                      input logic [31:0] d, input logic [32:0] e);
    bq.push_back(e);
    @(posedge i_core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ba(idx);
    pwdata  <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    do @(posedge i_core_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, {24'h000000, d}, 33'h000000000);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    xfer(idx, 1'b0, 32'h00000000, {25'h0000000, e});
  endtask

  // Queues a pin snapshot; the monitor compares it two edges later.
  task automatic pchk(input logic [31:0] e);
    pq.push_back(e);
    @(posedge i_core_clk);
    pin_chk <= 1'b1;
    @(posedge i_core_clk);
    pin_chk <= 1'b0;
  endtask

  task automatic results;
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Monitor: takes the oldest note whenever a result appears.
  always @(posedge i_core_clk) begin
    if (psel && penable && pready) begin
      eb = bq.pop_front();
      chk("apb", eb, {pslverr, pwrite ? eb[31:0] : prdata});
    end
    if (pin_chk) begin
      chk("pins", {1'b0, pq.pop_front()}, {1'b0, o_p8_oe,
          o_p8_out & o_p8_oe, o_p7_oe, o_p7_out & o_p7_oe});
    end
  end

  // Hang guard.
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    i_core_clk  = 1'b0;
    i_arst_n    = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 32'h00000000;
    pwdata      = 32'h00000000;
    pin_chk     = 1'b0;
    i_pwr_mode  = SSIO_ACTIVE;
    void'($urandom(11));
    i_seg7_data = 8'($urandom);
    i_seg8_data = 8'($urandom);
    i_p7_pin    = 8'($urandom);
    i_p8_pin    = 8'($urandom);
    {d7, l7, d8, l8} = 32'h00000000;
    s7 = i_seg7_data;
    s8 = i_seg8_data;
    pchk(32'h00000000);
    repeat (6) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    // Reset state and read-back of the write-only port 8 direction.
    pchk(ep(4'h0));
    rd(`SSIO_IDX_P8_DIR, 8'hFF);
    rd(`SSIO_IDX_P8_LATCH, i_p8_pin);
    wr(`SSIO_IDX_P8_DIR, 8'hFF);
    d8 = 8'hFF;
    rd(`SSIO_IDX_P8_LATCH, 8'h00);
    // All port 8 pins drive: a latch write must reach every pin.
    l8 = 8'($urandom);
    wr(`SSIO_IDX_P8_LATCH, l8);
    pchk(ep(4'h0));
    // Random direction, latch and pin mixes on both ports.
    repeat (8) begin
      d7 = 8'($urandom);
      l7 = 8'($urandom);
      d8 = 8'($urandom);
      l8 = 8'($urandom);
      wr(`SSIO_IDX_P8_DIR, d8);
      wr(`SSIO_IDX_P8_LATCH, l8);
      wr(`SSIO_IDX_P7_DIR, d7);
      wr(`SSIO_IDX_P7_LATCH, l7);
      i_p8_pin <= 8'($urandom);
      i_p7_pin <= 8'($urandom);
      repeat (3) @(posedge i_core_clk);
      rd(`SSIO_IDX_P8_LATCH, (l8 & d8) | (i_p8_pin & ~d8));
      rd(`SSIO_IDX_P7_LATCH, (l7 & d7) | (i_p7_pin & ~d7));
      rd(`SSIO_IDX_P8_DIR, 8'hFF);
      rd(`SSIO_IDX_P7_DIR, 8'hFF);
      pchk(ep(4'h0));
    end
    // Every segment_select code against both ports.
    for (int g = 0; g < 16; g++) begin
      s7 = 8'($urandom);
      s8 = 8'($urandom);
      i_seg7_data <= s7;
      i_seg8_data <= s8;
      wr(`SSIO_IDX_LCD_CTRL, 8'(g));
      rd(`SSIO_IDX_LCD_CTRL, 8'(g));
      pchk(ep(4'(g)));
    end
    // Power modes: hold, high impedance, functional.
    wr(`SSIO_IDX_LCD_CTRL, 8'h00);
    foreach (hm[i]) begin
      pchk(ep(4'h0));
      e0 = ep(4'h0);
      i_pwr_mode <= hm[i];
      l8 = 8'($urandom);
      wr(`SSIO_IDX_P8_LATCH, l8);
      pchk(e0);
      i_pwr_mode <= SSIO_ACTIVE;
      pchk(ep(4'h0));
    end
    i_pwr_mode <= SSIO_STANDBY;
    pchk(32'h00000000);
    i_pwr_mode <= SSIO_SUBACTIVE;
    l8 = ~l8;
    wr(`SSIO_IDX_P8_LATCH, l8);
    pchk(ep(4'h0));
    // Unmapped address is refused with an error.
    xfer(16'hFF00, 1'b1, 32'hFFFFFFFF, {1'b1, 32'h00000000});
    xfer(16'hFF00, 1'b0, 32'h00000000, {1'b1, 32'h00000000});
    rd(`SSIO_IDX_P8_LATCH, (l8 & d8) | (i_p8_pin & ~d8));
    repeat (2) @(posedge i_core_clk);
    results();
  end
endmodule
